/* mipc_top.sv */
// Maskable interrupt priority controller with APB register access.
// Assumes requests are one-cycle pulses synchronous to pclk.
// Functional notes
// RQ1: One control register per interrupt source
// RQ2: Individual priority for 27 sources, fixed order
// RQ3: Four levels, shared levels, level 0 highest
// RQ4: Simultaneous equal-level requests: lowest source first
// RQ5: Reset sets priority bits to lowest level
// RQ6: Single-bit set/clear leaves other bits
// RQ7: Group masks alias per-source masks, half access
// RQ8: In-service record holds accepted levels
// RQ9: Nest control allows level-3 into level-3
// RQ10: Pin and watchdog selectable maskable or non-maskable
// RQ11: Watchdog mode orders pin versus watchdog NMI
// RQ12: Global enable gates maskable acceptance
// RQ13: Source request sets its pending flag
// RQ14: Per-source transfer select and context select
// RQ15: Acknowledge clears flag; software may write
// RQ16: Mask 0 enables, covers transfers, reset sets
// RQ17: Transfer select clears on counter end
// RQ18: Priority bits 00..11 decode to levels 0..3
// RQ19: Present best unmasked level above in-service
// RQ20: Shared-register source pairs raise one flag
//
// The APB interface to the registers and the address map were left to the implementer.
`timescale 1ns/100ps
module mipc_top
    import mipc_pkg::*;
(
    // Clock, reset, enable
    input  wire logic                 pclk,
    input  wire logic                 presetn,
    input  wire logic                 clk_en,
    // APB slave
    input  wire logic                 psel,
    input  wire logic                 penable,
    input  wire logic                 pwrite,
    input  wire logic [11:0]          paddr,
    input  wire logic [31:0]          pwdata,
    input  wire logic [3:0]           pstrb,
    output logic                      pready,
    output logic [31:0]               prdata,
    output logic                      pslverr,
    // Interrupt sources
    input  wire logic [NUM_SRC-1:0]   src_req,
    input  wire logic [NUM_SRC-1:0]   src_req_alt,
    input  wire logic                 ext_irq_pin,
    input  wire logic                 watchdog_irq,
    input  wire logic [NUM_SRC-1:0]   xfer_count_done,
    // CPU handshake
    input  wire logic                 irq_ack,
    input  wire logic                 irq_return,
    // Requests to CPU
    output logic                      irq_valid,
    output logic [SRC_W-1:0]          irq_src,
    output logic [1:0]                irq_level,
    output logic                      irq_xfer,
    output logic                      irq_ctx,
    output logic                      nmi_valid,
    output logic                      nmi_is_wdog
);
    import mipc_pkg::*;

    // Per-source state, in-service record and mode registers
    logic [NUM_SRC-1:0]   req_pending_flag;
    logic [NUM_SRC-1:0]   req_mask_flag;
    logic [NUM_SRC-1:0]   transfer_service_select;
    logic [NUM_SRC-1:0]   ctx_swap_select;
    logic [2*NUM_SRC-1:0] prio_level_bits;
    logic [NUM_LVL-1:0]   in_service_level_rec;
    logic                 lowest_level_nest_ctrl;
    logic [1:0]           nonmask_source_select;
    logic                 watchdog_mode_setting;
    logic                 global_irq_enable;

    // APB decode
    wire        acc      = psel && penable;
    wire        wr       = acc && pwrite && clk_en;
    wire        rd       = psel && !penable && !pwrite;
    wire [6:0]  widx     = paddr[8:2];
    wire        hit_ctrl = paddr <= OFF_CTRL_LAST && paddr[1:0] == 2'h0;
    wire        hit_mlo  = paddr == OFF_MASK_LO;
    wire        hit_mhi  = paddr == OFF_MASK_HI;
    wire        hit_isr  = paddr == OFF_IN_SERVICE;
    wire        hit_nest = paddr == OFF_NEST_CTRL;
    wire        hit_nmi  = paddr == OFF_NMI_SEL;
    wire        hit_wdm  = paddr == OFF_WDOG_MODE;
    wire        hit_sw   = paddr == OFF_STATUS_WD;
    wire        hit_bop  = paddr == OFF_BITOP;
    wire        hit_ack  = paddr == OFF_ACK_INFO;
    wire        hit_any  = hit_ctrl | hit_mlo | hit_mhi | hit_isr | hit_nest
                         | hit_nmi | hit_wdm | hit_sw | hit_bop | hit_ack;
    wire [SRC_W-1:0] bop_src = pwdata[SRC_W-1:0];
    wire [2:0]  bop_pos  = pwdata[BITOP_POS_LSB +: 3];
    wire        bop_val  = pwdata[BITOP_VAL];
    wire        bop_wr   = wr && hit_bop && pstrb[0] && pstrb[1]
                         && bop_src < SRC_W'(NUM_SRC);
    wire        ctrl_wr  = wr && hit_ctrl && pstrb[0];

    // Combined mask image for group registers
    wire [31:0] mask_img = {{(32-NUM_SRC){1'b0}}, req_mask_flag};

    // Shared-register sources fold onto one request
    wire [NUM_SRC-1:0] raw_req = src_req | src_req_alt; // RQ20

    // Pin and watchdog: route to maskable path or non-maskable path
    wire [NUM_SRC-1:0] nmi_steal = (NUM_SRC'(nonmask_source_select[NMI_WDOG_BIT]) << SRC_WDOG)
                                 | (NUM_SRC'(nonmask_source_select[NMI_PIN_BIT]) << SRC_EXTPIN);
    wire [NUM_SRC-1:0] mask_raw  = raw_req
                                 | (NUM_SRC'(watchdog_irq) << SRC_WDOG)
                                 | (NUM_SRC'(ext_irq_pin) << SRC_EXTPIN);
    wire [NUM_SRC-1:0] set_req   = mask_raw & ~nmi_steal; // RQ10
    wire nmi_wd_req  = watchdog_irq && nonmask_source_select[NMI_WDOG_BIT];
    wire nmi_pin_req = ext_irq_pin && nonmask_source_select[NMI_PIN_BIT];

    // Level gating of vectored requests
    logic [NUM_SRC-1:0] eligible;
    logic [1:0]         best_isr;
    logic               isr_busy;
    always_comb
    begin
        best_isr = LVL_LOWEST;
        isr_busy = |in_service_level_rec;
        for (int l = NUM_LVL - 1; l >= 0; l--)
        begin
            if (in_service_level_rec[l])
            begin
                best_isr = 2'(l);
            end
        end
        for (int i = 0; i < NUM_SRC; i++)
        begin
            // Mask 0 enables, 1 blocks; transfers are masked too
            eligible[i] = req_pending_flag[i] && !req_mask_flag[i]; // RQ16
            if (!transfer_service_select[i])
            begin
                // Must beat every level in service; level 3 nests on request
                eligible[i] = eligible[i] && global_irq_enable // RQ12
                    && (!isr_busy || prio_level_bits[2*i +: 2] < best_isr
                        || (lowest_level_nest_ctrl && best_isr == LVL_LOWEST
                            && prio_level_bits[2*i +: 2] == LVL_LOWEST)); // RQ9 RQ19
            end
        end
    end

    logic             sel_found;
    logic [SRC_W-1:0] sel_src;
    logic [1:0]       sel_level;
    mipc_prio_select u_sel (
        .eligible  (eligible),
        .levels    (prio_level_bits),
        .found     (sel_found),
        .winner    (sel_src),
        .win_level (sel_level)
    ); // RQ2 RQ3 RQ4 RQ18

    wire ack_take = irq_ack && irq_valid;
    wire [NUM_SRC-1:0] ack_clr = ack_take ? (NUM_SRC'(1) << irq_src) : '0;

    // Next pending: set wins over all three clears
    wire [NUM_SRC-1:0] sw_req_clr = NUM_SRC'(ctrl_wr && !pwdata[BIT_REQ]) << widx[SRC_W-1:0];
    wire [NUM_SRC-1:0] sw_req_set = NUM_SRC'(ctrl_wr && pwdata[BIT_REQ]) << widx[SRC_W-1:0];
    wire [NUM_SRC-1:0] bop_hit    = NUM_SRC'(bop_wr) << bop_src;
    wire [NUM_SRC-1:0] bop_set    = bop_hit & {NUM_SRC{bop_val}};
    wire [NUM_SRC-1:0] bop_clr    = bop_hit & {NUM_SRC{!bop_val}};
    wire [NUM_SRC-1:0] next_req   = set_req | sw_req_set // RQ13
        | (bop_set & {NUM_SRC{bop_pos == 3'(BIT_REQ)}})
        | (req_pending_flag & ~sw_req_clr & ~ack_clr // RQ15
           & ~(bop_clr & {NUM_SRC{bop_pos == 3'(BIT_REQ)}}));

    // In-service: acceptance sets level bit, return clears highest
    logic [NUM_LVL-1:0] ret_clr;
    always_comb
    begin
        ret_clr = '0;
        if (irq_return && isr_busy)
        begin
            ret_clr[best_isr] = 1'b1;
        end
    end
    wire [NUM_LVL-1:0] isr_set = (ack_take && !irq_xfer) ? (NUM_LVL'(1) << irq_level) : '0;
    wire [NUM_LVL-1:0] next_isr = (in_service_level_rec & ~ret_clr) | isr_set; // RQ8

    // Per-source control bits
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            req_mask_flag           <= '1; // RQ16
            transfer_service_select <= '0;
            ctx_swap_select         <= '0;
            prio_level_bits         <= '1; // RQ5
        end
        else if (clk_en)
        begin
            for (int i = 0; i < NUM_SRC; i++)
            begin
                if (ctrl_wr && widx == 7'(i))
                begin
                    req_mask_flag[i]            <= pwdata[BIT_MASK]; // RQ1
                    transfer_service_select[i]  <= pwdata[BIT_XFER];
                    ctx_swap_select[i]          <= pwdata[BIT_CTX];
                    prio_level_bits[2*i +: 2]   <= pwdata[BIT_PR1:BIT_PR0];
                end
                else if (bop_wr && bop_src == SRC_W'(i))
                begin
                    // Single-bit update, neighbours unchanged
                    if (bop_pos == 3'(BIT_MASK))
                        req_mask_flag[i] <= bop_val;
                    if (bop_pos == 3'(BIT_XFER))
                        transfer_service_select[i] <= bop_val;
                    if (bop_pos == 3'(BIT_CTX))
                        ctx_swap_select[i] <= bop_val;
                    if (bop_pos == 3'(BIT_PR1))
                        prio_level_bits[2*i+1] <= bop_val; // RQ6
                    if (bop_pos == 3'(BIT_PR0))
                        prio_level_bits[2*i] <= bop_val; // RQ6
                end
                if (wr && hit_mlo && i < MASK_LO_W)
                begin
                    if ((i < 8 && pstrb[0]) || (i >= 8 && pstrb[1]))
                        req_mask_flag[i] <= pwdata[i]; // RQ7
                end
                if (wr && hit_mhi && i >= MASK_LO_W)
                begin
                    if ((i < MASK_LO_W + 8 && pstrb[0]) || (i >= MASK_LO_W + 8 && pstrb[1]))
                        req_mask_flag[i] <= pwdata[i-MASK_LO_W]; // RQ7
                end
                if (xfer_count_done[i])
                    transfer_service_select[i] <= 1'b0; // RQ17
            end
        end
    end

    // Pending flags, mode registers, in-service record
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            req_pending_flag       <= '0;
            in_service_level_rec   <= '0;
            lowest_level_nest_ctrl <= 1'b0;
            nonmask_source_select  <= '0;
            watchdog_mode_setting  <= 1'b0;
            global_irq_enable      <= 1'b0;
        end
        else if (clk_en)
        begin
            req_pending_flag     <= next_req;
            in_service_level_rec <= next_isr;
            if (wr && hit_nest && pstrb[0])
                lowest_level_nest_ctrl <= pwdata[0];
            if (wr && hit_nmi && pstrb[0])
                nonmask_source_select <= pwdata[1:0];
            if (wr && hit_wdm && pstrb[0])
                watchdog_mode_setting <= pwdata[WDOG_PRIO_BIT];
            if (wr && hit_sw && pstrb[0])
                global_irq_enable <= pwdata[STATUS_IE_BIT];
        end
    end

    // Read mux
    logic [31:0] rd_mux;
    always_comb
    begin
        rd_mux = '0;
        if (hit_ctrl && widx < 7'(NUM_SRC))
        begin
            rd_mux[BIT_REQ]         = req_pending_flag[widx[SRC_W-1:0]];
            rd_mux[BIT_MASK]        = req_mask_flag[widx[SRC_W-1:0]];
            rd_mux[BIT_XFER]        = transfer_service_select[widx[SRC_W-1:0]];
            rd_mux[BIT_CTX]         = ctx_swap_select[widx[SRC_W-1:0]];
            rd_mux[BIT_PR1:BIT_PR0] = prio_level_bits[2*widx[SRC_W-1:0] +: 2];
        end
        if (hit_mlo)  rd_mux = {16'h0000, mask_img[15:0]};
        if (hit_mhi)  rd_mux = {16'h0000, mask_img[31:16]};
        if (hit_isr)  rd_mux = {28'h0000000, in_service_level_rec};
        if (hit_nest) rd_mux = {31'h00000000, lowest_level_nest_ctrl};
        if (hit_nmi)  rd_mux = {30'h00000000, nonmask_source_select};
        if (hit_wdm)  rd_mux = {31'h00000000, watchdog_mode_setting};
        if (hit_sw)   rd_mux = {31'h00000000, global_irq_enable};
        if (hit_ack)  rd_mux = {24'h000000, irq_level, irq_src, irq_valid};
    end

    // Outputs: APB answer in the first access cycle, request registers
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready      <= 1'b0;
            prdata      <= '0;
            pslverr     <= 1'b0;
            irq_valid   <= 1'b0;
            irq_src     <= '0;
            irq_level   <= LVL_LOWEST;
            irq_xfer    <= 1'b0;
            irq_ctx     <= 1'b0;
            nmi_valid   <= 1'b0;
            nmi_is_wdog <= 1'b0;
        end
        else if (clk_en)
        begin
            pready      <= psel && !penable;
            pslverr     <= psel && !penable && !hit_any;
            prdata      <= rd ? rd_mux : '0;
            irq_valid   <= sel_found && !ack_take; // RQ19
            irq_src     <= sel_src;
            irq_level   <= sel_level;
            irq_xfer    <= transfer_service_select[sel_src]; // RQ14
            irq_ctx     <= ctx_swap_select[sel_src] && !transfer_service_select[sel_src];
            nmi_valid   <= nmi_wd_req || nmi_pin_req;
            // Mode 1 puts watchdog ahead of pin
            nmi_is_wdog <= nmi_wd_req && (watchdog_mode_setting || !nmi_pin_req); // RQ11
        end
    end

    AST_RESET_LOWEST: assert property (@(posedge pclk) $rose(presetn) // RQ5
        |-> prio_level_bits == '1 && req_mask_flag == '1)
        else $error("priority or mask not at reset value");
    AST_IE_GATES: assert property (@(posedge pclk) disable iff (!presetn) // RQ12
        clk_en && !global_irq_enable && !(|transfer_service_select) |=> !irq_valid)
        else $error("maskable request presented while disabled");
    AST_MASKED_NEVER: assert property (@(posedge pclk) disable iff (!presetn) // RQ16
        $past(clk_en) && irq_valid |-> $past(!req_mask_flag[sel_src]))
        else $error("masked source presented");
    AST_REQ_SET: assert property (@(posedge pclk) disable iff (!presetn) // RQ13
        clk_en && set_req != '0 |=> (req_pending_flag & $past(set_req)) == $past(set_req))
        else $error("request flag not set");
    AST_ACK_CLEARS: assert property (@(posedge pclk) disable iff (!presetn) // RQ15
        clk_en && ack_take && !set_req[irq_src] && !bop_wr && !ctrl_wr
        |=> !req_pending_flag[$past(irq_src)])
        else $error("ack did not clear request flag");
    AST_ISR_SET: assert property (@(posedge pclk) disable iff (!presetn) // RQ8
        clk_en && ack_take && !irq_xfer |=> in_service_level_rec[$past(irq_level)])
        else $error("in-service level not recorded");
    AST_XFER_END: assert property (@(posedge pclk) disable iff (!presetn) // RQ17
        clk_en && xfer_count_done != '0
        |=> (transfer_service_select & $past(xfer_count_done)) == '0)
        else $error("transfer select not cleared");
    AST_NMI_STEAL: assert property (@(posedge pclk) disable iff (!presetn) // RQ10
        clk_en && watchdog_irq && nonmask_source_select[NMI_WDOG_BIT]
        |=> nmi_valid && nmi_is_wdog || nmi_valid && !watchdog_mode_setting)
        else $error("watchdog not routed to non-maskable path");
    AST_LEVEL_ABOVE: assert property (@(posedge pclk) disable iff (!presetn) // RQ19
        irq_valid && !irq_xfer && $past(in_service_level_rec[0]) |-> 0)
        else $error("request presented over level 0 in service");
endmodule // mipc_top

/* mipc_pkg.sv */
// Package for the maskable interrupt priority controller.
// Holds register map, field positions, reset values and source count.
package mipc_pkg;
    localparam int          NUM_SRC        = 27;
    localparam int          SRC_W          = 5;
    localparam int          NUM_LVL        = 4;
    localparam logic [1:0]  LVL_LOWEST     = 2'h3;
    // Control register fields
    localparam int          BIT_REQ        = 7;
    localparam int          BIT_MASK       = 6;
    localparam int          BIT_XFER       = 5;
    localparam int          BIT_CTX        = 4;
    localparam int          BIT_PR1        = 1;
    localparam int          BIT_PR0        = 0;
    localparam logic [7:0]  CTRL_RESET     = 8'h43;
    localparam logic [7:0]  CTRL_WMASK     = 8'hF3;
    // Register map: control registers at index*4 from 0x000
    localparam logic [11:0] OFF_CTRL_BASE  = 12'h000;
    localparam logic [11:0] OFF_CTRL_LAST  = 12'h068;
    localparam logic [11:0] OFF_MASK_LO    = 12'h080;
    localparam logic [11:0] OFF_MASK_HI    = 12'h084;
    localparam logic [11:0] OFF_IN_SERVICE = 12'h088;
    localparam logic [11:0] OFF_NEST_CTRL  = 12'h08C;
    localparam logic [11:0] OFF_NMI_SEL    = 12'h090;
    localparam logic [11:0] OFF_WDOG_MODE  = 12'h094;
    localparam logic [11:0] OFF_STATUS_WD  = 12'h098;
    localparam logic [11:0] OFF_BITOP      = 12'h09C;
    localparam logic [11:0] OFF_ACK_INFO   = 12'h0A0;
    // Bit-operation register fields: [12] set/clear, [10:8] bit, [4:0] source
    localparam int          BITOP_VAL      = 12;
    localparam int          BITOP_POS_LSB  = 8;
    localparam int          MASK_LO_W      = 16;
    localparam int          STATUS_IE_BIT  = 0;
    localparam int          WDOG_PRIO_BIT  = 0;
    localparam int          NMI_WDOG_BIT   = 0;
    localparam int          NMI_PIN_BIT    = 1;
    // Fixed source indices
    localparam logic [4:0]  SRC_WDOG       = 5'h00;
    localparam logic [4:0]  SRC_EXTPIN     = 5'h01;
endpackage : mipc_pkg

/* mipc_prio_select.sv */
// Priority resolver: picks the best level among eligible requests,
// ties broken by lowest source number. Purely combinational.
`timescale 1ns/100ps
module mipc_prio_select
    import mipc_pkg::*;
(
    // Candidates
    input  wire logic [NUM_SRC-1:0]   eligible,
    input  wire logic [2*NUM_SRC-1:0] levels,
    // Result
    output logic                      found,
    output logic [SRC_W-1:0]          winner,
    output logic [1:0]                win_level
);
    always_comb
    begin
        found     = 1'b0;
        winner    = '0;
        win_level = LVL_LOWEST;
        // Descending scan: the lowest number wins equal levels
        for (int i = NUM_SRC - 1; i >= 0; i--)
        begin
            if (eligible[i] && (!found || levels[2*i +: 2] <= win_level))
            begin
                found     = 1'b1;
                winner    = SRC_W'(i);
                win_level = levels[2*i +: 2];
            end
        end
    end
endmodule // mipc_prio_select

/* mipc_cpu_model.sv */
// CPU model for the interrupt controller bench: acknowledges presented requests.
// Assumes the single pclk domain and registered irq_valid/irq_src from the controller.
`timescale 1ns/100ps
module mipc_cpu_model
(
    // Clock and reset
    input  wire logic                       pclk,
    input  wire logic                       presetn,
    // Controller side
    input  wire logic                       irq_valid,
    input  wire logic [mipc_pkg::SRC_W-1:0] irq_src,
    output logic                            irq_ack,
    // Bench control and record
    input  wire logic                       ack_en,
    input  wire logic [3:0]                 ack_wait,
    output logic [mipc_pkg::SRC_W-1:0]      taken_src,
    output logic [7:0]                      taken_cnt
);
    import mipc_pkg::*;
    logic [3:0] wait_cnt;
    // One-cycle acknowledge after ack_wait cycles of a presented request
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            irq_ack   <= 1'b0;
            wait_cnt  <= 4'h0;
            taken_src <= '0;
            taken_cnt <= 8'h00;
        end
        else if (irq_ack)
            irq_ack <= 1'b0;
        else if (ack_en && irq_valid && wait_cnt >= ack_wait)
        begin
            irq_ack   <= 1'b1;
            taken_src <= irq_src;
            taken_cnt <= taken_cnt + 8'h01;
            wait_cnt  <= 4'h0;
        end
        else if (ack_en && irq_valid)
            wait_cnt <= wait_cnt + 4'h1;
    end
endmodule // mipc_cpu_model

/* maskable_interrupt_priority_control_bench.sv */
// Self-checking bench for the interrupt priority controller over APB.
// Assumes the CPU model above; clk_en is held high throughout.
`timescale 1ns/100ps
module maskable_interrupt_priority_control_bench;
    import mipc_pkg::*;
    typedef struct packed {logic [4:0] src; logic [1:0] pr; logic ctx; logic alt;
                           logic [3:0] wt;} mipc_row_s;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, rdat;
    logic [3:0] pstrb = '0, ack_wait = '0;
    logic [NUM_SRC-1:0] src_req = '0, src_req_alt = '0, xfer_count_done = '0;
    logic ext_irq_pin = 0, watchdog_irq = 0, irq_ack, irq_return = 0, ack_en = 0, rerr;
    logic irq_valid, irq_xfer, irq_ctx, nmi_valid, nmi_is_wdog;
    logic [SRC_W-1:0] irq_src, taken_src;
    logic [1:0] irq_level;
    logic [7:0] taken_cnt;
    int miscompares = 0, comparisons = 0, n;
    mipc_row_s rows [5] = '{'{0, 0, 0, 0, 0}, '{5, 1, 1, 0, 3}, '{13, 2, 0, 1, 1},
                           '{26, 3, 0, 0, 5}, '{20, 2, 1, 1, 0}};
    logic [31:0] bitops [3][2] = '{'{32'h0004, 32'h42}, '{32'h0104, 32'h40}, '{32'h1004, 32'h41}};
    always #50 pclk = ~pclk;
    mipc_top dut (.pclk(pclk), .presetn(presetn), .clk_en(1'b1), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready),
        .prdata(prdata), .pslverr(pslverr), .src_req(src_req), .src_req_alt(src_req_alt),
        .ext_irq_pin(ext_irq_pin), .watchdog_irq(watchdog_irq), .xfer_count_done(xfer_count_done),
        .irq_ack(irq_ack), .irq_return(irq_return), .irq_valid(irq_valid), .irq_src(irq_src),
        .irq_level(irq_level), .irq_xfer(irq_xfer), .irq_ctx(irq_ctx), .nmi_valid(nmi_valid),
        .nmi_is_wdog(nmi_is_wdog));
    mipc_cpu_model cpu (.pclk(pclk), .presetn(presetn), .irq_valid(irq_valid), .irq_src(irq_src),
        .irq_ack(irq_ack), .ack_en(ack_en), .ack_wait(ack_wait), .taken_src(taken_src),
        .taken_cnt(taken_cnt));
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        comparisons++;
        if (s !== e)
        begin
            miscompares++;
            $display("[FAIL] %0t seen %h expected %h", $time, s, e);
        end
    endtask
    task automatic summarize();
        if (miscompares == 0 && comparisons > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // Setup then access phase; held until pready is sampled high
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       input logic [3:0] s);
        int k;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do
        begin
            @(posedge pclk);
            k++;
        end
        while (pready !== 1'b1 && k < 16);
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (k >= 16)
            miscompares++;
    endtask
    task automatic clr();
        @(posedge pclk);
        src_req <= '0;
        src_req_alt <= '0;
        ext_irq_pin <= 1'b0;
        watchdog_irq <= 1'b0;
        xfer_count_done <= '0;
    endtask
    task automatic wait_valid(input logic [4:0] s, input logic [1:0] l);
        for (n = 0; n < 8 && irq_valid !== 1'b1; n++)
            @(posedge pclk);
        chk(irq_valid, 1);
        chk(irq_src, s);
        chk(irq_level, l);
    endtask
    task automatic ack(input logic r);
        logic [7:0] c;
        @(posedge pclk);
        ack_en <= 1'b1;
        c = taken_cnt;
        for (n = 0; n < 20 && taken_cnt === c; n++)
            @(posedge pclk);
        ack_en <= 1'b0;
        irq_return <= r;
        @(posedge pclk);
        irq_return <= 1'b0;
    endtask
    task automatic fire(input logic [26:0] m);
        @(posedge pclk);
        src_req <= m;
        clr();
    endtask
    initial
    begin
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        apb(0, 12'h000, 0, 4'hF); chk(rdat, 32'h43);
        apb(0, 12'h068, 0, 4'hF); chk(rdat, 32'h43);
        apb(0, OFF_MASK_HI, 0, 4'hF); chk(rdat, 32'h7FF);
        chk(irq_level, 2'h3);
        apb(1, OFF_STATUS_WD, 1, 4'hF);
        foreach (rows[i])
        begin
            apb(1, {5'h0, rows[i].src, 2'b00}, {rows[i].ctx, 2'b00, rows[i].pr}, 4'hF);
            @(posedge pclk);
            ack_wait <= rows[i].wt;
            src_req <= rows[i].alt ? '0 : 27'(1) << rows[i].src;
            src_req_alt <= rows[i].alt ? 27'(1) << rows[i].src : '0;
            clr();
            wait_valid(rows[i].src, rows[i].pr);
            chk(irq_ctx, rows[i].ctx);
            ack(0);
            chk(taken_src, rows[i].src);
            apb(0, OFF_IN_SERVICE, 0, 4'hF); chk(rdat[rows[i].pr], 1);
            ack(1);
            apb(0, {5'h0, rows[i].src, 2'b00}, 0, 4'hF); chk(rdat[7], 0);
            apb(1, {5'h0, rows[i].src, 2'b00}, 32'h43, 4'hF);
        end
        apb(1, 12'h00C, 32'h01, 4'hF);
        apb(1, 12'h024, 32'h01, 4'hF);
        fire(27'h208);
        wait_valid(3, 1);
        ack(0);
        repeat (3) @(posedge pclk);
        chk(irq_valid, 0);
        ack(1);
        wait_valid(9, 1);
        ack(1);
        apb(1, 12'h024, 32'h00, 4'hF);
        apb(1, 12'h00C, 32'h02, 4'hF);
        fire(27'h208);
        wait_valid(9, 0);
        ack(1);
        ack(1);
        apb(1, OFF_STATUS_WD, 0, 4'hF);
        fire(27'h008);
        repeat (4) @(posedge pclk);
        chk(irq_valid, 0);
        apb(1, OFF_STATUS_WD, 1, 4'hF);
        wait_valid(3, 2);
        ack(1);
        apb(1, 12'h008, 32'h03, 4'hF);
        apb(1, 12'h01C, 32'h03, 4'hF);
        fire(27'h004);
        ack(0);
        fire(27'h080);
        repeat (4) @(posedge pclk);
        chk(irq_valid, 0);
        apb(1, OFF_NEST_CTRL, 1, 4'hF);
        wait_valid(7, 3);
        ack(1);
        ack(1);
        apb(1, OFF_STATUS_WD, 0, 4'hF);
        apb(1, 12'h018, 32'h23, 4'hF);
        fire(27'h040);
        wait_valid(6, 3);
        chk(irq_xfer, 1);
        apb(0, OFF_ACK_INFO, 0, 4'hF); chk(rdat, 32'hCD);
        ack(0);
        @(posedge pclk);
        xfer_count_done <= 27'h040;
        clr();
        apb(0, 12'h018, 0, 4'hF); chk(rdat, 32'h03);
        apb(1, OFF_MASK_LO, 0, 4'h2);
        apb(0, OFF_MASK_LO, 0, 4'hF); chk(rdat[15:8], 0);
        chk(rdat[0], 1);
        apb(0, 12'h028, 0, 4'hF); chk(rdat, 32'h03);
        apb(1, OFF_MASK_HI, 0, 4'h1);
        apb(0, OFF_MASK_HI, 0, 4'hF); chk(rdat, 32'h700);
        foreach (bitops[i])
        begin
            apb(1, OFF_BITOP, bitops[i][0], 4'h3);
            apb(0, 12'h010, 0, 4'hF); chk(rdat, bitops[i][1]);
        end
        apb(0, 12'h014, 0, 4'hF); chk(rdat, 32'h43);
        apb(1, OFF_NMI_SEL, 3, 4'hF);
        for (int m = 0; m < 2; m++)
        begin
            apb(1, OFF_WDOG_MODE, m, 4'hF);
            @(posedge pclk);
            ext_irq_pin <= 1'b1;
            watchdog_irq <= 1'b1;
            clr();
            for (n = 0; n < 4 && nmi_valid !== 1'b1; n++)
                @(posedge pclk);
            chk(nmi_valid, 1);
            chk(nmi_is_wdog, m);
        end
        apb(0, 12'hFFC, 0, 4'hF); chk(rerr, 1);
        apb(1, 12'hFF0, 1, 4'hF); chk(rerr, 1);
        @(posedge pclk);
        presetn <= 1'b0;
        @(posedge pclk);
        presetn <= 1'b1;
        apb(0, 12'h028, 0, 4'hF); chk(rdat, 32'h43);
        summarize();
    end
    initial
    begin
        repeat (20000) @(posedge pclk);
        miscompares++;
        summarize();
    end
endmodule // maskable_interrupt_priority_control_bench
